// ==== bench/sdt_proc_model.sv ====
`default_nettype none
module sdt_proc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic proc_evt,
  input wire logic adc_trig,
  output logic [7:0] wake_cnt,
  output logic [7:0] conv_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt <= 8'h00;
      conv_cnt <= 8'h00;
    end else begin
      wake_cnt <= wake_cnt + {7'h00, proc_evt};
      conv_cnt <= conv_cnt + {7'h00, adc_trig};
    end
  end
endmodule
`default_nettype wire

// ==== bench/sdt_top_sva.sv ====
`default_nettype none
module sdt_top_sva #(
  parameter int NUM_TICK = 8,
  parameter int NUM_CH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_TICK-1:0] tick_src,
  input wire logic [NUM_CH-1:0] cap_in,
  input wire logic [NUM_CH-1:0] cc_out,
  input wire logic proc_evt,
  input wire logic adc_trig,
  input wire logic irq
);
  logic wr_acc;
  logic map_ok;
  logic [6:0] mask_q;
  logic [12:0] evsel_q;
  logic [3:0] run_q;
  assign wr_acc = psel && penable && pready && pwrite;
  assign map_ok = (paddr[1:0] == 2'h0) && ((paddr <= 8'h28 && paddr[3:2] != 2'h3) ||
    paddr == 8'h2c || paddr == 8'h30 || paddr == 8'h34 || (paddr >= 8'h40 && paddr <= 8'h5c));
  // shadows of mask, event select and timer2 run history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 7'h00;
      evsel_q <= 13'h0000;
      run_q <= 4'h0;
    end else begin
      if (wr_acc && paddr == sdt_pkg::IRQ_MASK_OFF) mask_q <= pwdata[6:0];
      if (wr_acc && paddr == sdt_pkg::T2_EVSEL_OFF) evsel_q <= pwdata[12:0];
      run_q <= {run_q[2:0], (wr_acc && paddr == sdt_pkg::T2_CTRL_OFF) ? pwdata[0] : run_q[0]};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && !penable && !map_ok |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (psel && !penable && map_ok |=> !pslverr)
    else $error("mapped access refused");
  a_irq_masked: assert property (mask_q == 7'h00 && $past(mask_q) == 7'h00 |-> !irq)
    else $error("irq high with mask clear");
  a_irq_cause: assert property ($rose(irq) |-> mask_q != 7'h00 || $past(mask_q) != 7'h00)
    else $error("irq rose without mask");
  a_adc_evsel: assert property (adc_trig |-> evsel_q[12:8] != 5'h00 ||
    $past(evsel_q[12:8]) != 5'h00 || $past(evsel_q[12:8], 2) != 5'h00)
    else $error("adc trigger not selected");
  a_proc_evsel: assert property (proc_evt |-> evsel_q[4:0] != 5'h00 ||
    $past(evsel_q[4:0]) != 5'h00 || $past(evsel_q[4:0], 2) != 5'h00)
    else $error("processor event not selected");
  a_cc_stopped: assert property (run_q == 4'h0 |-> $stable(cc_out))
    else $error("channel output moved while stopped");
  a_evt_stopped: assert property (run_q == 4'h0 |-> !proc_evt && !adc_trig)
    else $error("event while timer2 stopped");
endmodule
bind sdt_top sdt_top_sva #(.NUM_TICK(NUM_TICK), .NUM_CH(NUM_CH)) u_sdt_top_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tick_src(tick_src), .cap_in(cap_in), .cc_out(cc_out), .proc_evt(proc_evt),
  .adc_trig(adc_trig), .irq(irq));
`default_nettype wire

// ==== bench/tb.sv ====
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] lo; logic [31:0] hi; logic err; logic rd;} sdt_exp_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, proc_evt, adc_trig, irq, lvl, cc0_q;
  logic [7:0] paddr, tick_src, wake_cnt, conv_cnt, tog_cnt;
  logic [31:0] pwdata, prdata;
  logic [3:0] cap_in, cc_out;
  int miscompares, samples_checked;
  sdt_exp_t exp_q[$];
  logic [7:0] ra [11] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h20, 8'h24, 8'h2c, 8'h30, 8'h34,
    8'h40, 8'h44};
  logic [31:0] rv [11] = '{32'h0, 32'hffff, 32'h0, 32'hffff, 32'h0, 32'hffff, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0};
  logic [31:0] tlo [3] = '{32'd236, 32'd18, 32'd0};
  logic [31:0] thi [3] = '{32'd246, 32'd22, 32'd1};
  sdt_top u_sdt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tick_src(tick_src), .cap_in(cap_in), .cc_out(cc_out),
    .proc_evt(proc_evt), .adc_trig(adc_trig), .irq(irq));
  sdt_proc_model u_sdt_proc_model (.pclk(pclk), .presetn(presetn), .proc_evt(proc_evt),
    .adc_trig(adc_trig), .wake_cnt(wake_cnt), .conv_cnt(conv_cnt));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic fail(input string m);
    miscompares++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic c, input string m);
    samples_checked++;
    if (c !== 1'b1) fail(m);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] lo, input logic [31:0] hi, input logic e);
    exp_q.push_back('{lo, hi, e, !w});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    apb(1'b0, a, 32'h0, lo, hi, 1'b0);
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      repeat (8) @(posedge pclk);
      lvl = ~lvl;
      tick_src <= 8'($urandom() & 32'hdf) | {2'h0, lvl, 5'h00};
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // result monitor
  always @(posedge pclk) begin
    sdt_exp_t x;
    cc0_q <= cc_out[0];
    if (cc_out[0] !== cc0_q) tog_cnt <= tog_cnt + 8'h01;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      x = exp_q.pop_front();
      samples_checked++;
      if (pslverr !== x.err || (x.rd && (^prdata === 1'bx || prdata < x.lo || prdata > x.hi)))
        fail($sformatf("addr %h data %h err %b", paddr, prdata, pslverr));
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail("timeout");
    summarize();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tick_src = 8'h00;
    cap_in = 4'h0;
    lvl = 1'b0;
    cc0_q = 1'b0;
    tog_cnt = 8'h00;
    miscompares = 0;
    samples_checked = 0;
    void'($urandom(56));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) rd(ra[i], rv[i], rv[i]);
    apb(1'b0, 8'h3c, 32'h0, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h60, 32'h1, 32'h0, 32'h0, 1'b1);
    // timer0 one-shot, divide by 16
    wr(sdt_pkg::T0_TARGET_OFF, 32'h3);
    wr(sdt_pkg::T0_CTRL_OFF, 32'h41);
    repeat (20) @(posedge pclk);
    rd(sdt_pkg::T0_COUNT_OFF, 32'h1, 32'h1);
    repeat (60) @(posedge pclk);
    rd(sdt_pkg::T0_COUNT_OFF, 32'h3, 32'h3);
    rd(sdt_pkg::T0_CTRL_OFF, 32'h40, 32'h40);
    rd(sdt_pkg::IRQ_STATUS_OFF, 32'h1, 32'h1);
    wr(sdt_pkg::T0_COUNT_OFF, 32'h7);
    rd(sdt_pkg::T0_COUNT_OFF, 32'h3, 32'h3);
    // timer1 periodic on tick line 5, noise elsewhere
    wr(sdt_pkg::T1_TARGET_OFF, 32'h2);
    wr(sdt_pkg::T1_CTRL_OFF, 32'h507);
    ticks(7);
    repeat (8) @(posedge pclk);
    rd(sdt_pkg::T1_COUNT_OFF, 32'h1, 32'h1);
    rd(sdt_pkg::T1_CTRL_OFF, 32'h507, 32'h507);
    wr(sdt_pkg::T1_CTRL_OFF, 32'h506);
    rd(sdt_pkg::IRQ_STATUS_OFF, 32'h3, 32'h3);
    wr(sdt_pkg::IRQ_STATUS_OFF, 32'h7f);
    rd(sdt_pkg::IRQ_STATUS_OFF, 32'h0, 32'h0);
    // timer2 rate for each clock select
    for (int s = 0; s < 3; s++) begin
      wr(sdt_pkg::T2_CTRL_OFF, 32'h1 | (32'(s) << 2));
      repeat (1000) @(posedge pclk);
      rd(sdt_pkg::T2_COUNT_OFF, tlo[s], thi[s]);
      wr(sdt_pkg::T2_CTRL_OFF, 32'h0);
    end
    // periodic timer2, channels: periodic compare, one-shot capture, one-shot compare
    wr(sdt_pkg::CH_VAL_OFF, 32'd10);
    wr(sdt_pkg::CH_CFG_OFF, 32'h5);
    wr(sdt_pkg::CH_CFG_OFF + sdt_pkg::CH_STRIDE, 32'h3);
    wr(sdt_pkg::CH_VAL_OFF + 8'h10, 32'd5);
    wr(sdt_pkg::CH_CFG_OFF + 8'h10, 32'h1);
    wr(sdt_pkg::T2_PERIOD_OFF, 32'd99);
    wr(sdt_pkg::T2_EVSEL_OFF, 32'h201);
    wr(sdt_pkg::IRQ_MASK_OFF, 32'h8);
    wr(sdt_pkg::T2_CTRL_OFF, 32'h3);
    repeat (300) @(posedge pclk);
    cap_in <= 4'h2;
    repeat (10) @(posedge pclk);
    cap_in <= 4'h0;
    repeat (700) @(posedge pclk);
    wr(sdt_pkg::T2_CTRL_OFF, 32'h0);
    repeat (10) @(posedge pclk);
    chk(irq === 1'b1, "irq not raised");
    chk(cc_out === 4'h5, "channel outputs");
    chk(conv_cnt === 8'd3 && tog_cnt === 8'd3, "adc trigger count");
    chk(wake_cnt === 8'd2, "processor event count");
    rd(sdt_pkg::CH_CFG_OFF, 32'h5, 32'h5);
    rd(sdt_pkg::CH_CFG_OFF + sdt_pkg::CH_STRIDE, 32'h2, 32'h2);
    rd(sdt_pkg::CH_CFG_OFF + 8'h10, 32'h0, 32'h0);
    rd(sdt_pkg::CH_VAL_OFF + sdt_pkg::CH_STRIDE, 32'd0, 32'd99);
    rd(sdt_pkg::IRQ_STATUS_OFF, 32'h3c, 32'h3c);
    // interrupt mask and clear
    wr(sdt_pkg::IRQ_MASK_OFF, 32'h0);
    repeat (3) @(posedge pclk);
    chk(irq === 1'b0, "irq not masked");
    wr(sdt_pkg::IRQ_MASK_OFF, 32'h8);
    repeat (3) @(posedge pclk);
    chk(irq === 1'b1, "irq not unmasked");
    wr(sdt_pkg::IRQ_STATUS_OFF, 32'h7f);
    repeat (3) @(posedge pclk);
    chk(irq === 1'b0, "irq not cleared");
    rd(sdt_pkg::IRQ_STATUS_OFF, 32'h0, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire

// ==== rtl/sdt_basic_timer.sv ====
`default_nettype none
module sdt_basic_timer #(
  parameter int CNT_W = 16,
  parameter int PRESC_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic periodic_i,
  input wire logic use_tick_i,
  input wire logic [PRESC_W-1:0] prescale_i,
  input wire logic tick_i,
  input wire logic [CNT_W-1:0] target_i,
  output logic [CNT_W-1:0] count_o,
  output logic running_o,
  output logic done_o
);
  logic [CNT_W-1:0] pre_q;
  logic [CNT_W-1:0] pre_mask;
  logic pre_hit;
  logic inc;
  logic hit;

  ////////////////////////////////////////////////////////////////////////
  // [RL2] power-of-two prescaler
  assign pre_mask = ~({CNT_W{1'b1}} << prescale_i);
  assign pre_hit = running_o && ((pre_q & pre_mask) == pre_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (start_i || pre_hit) begin
      pre_q <= '0;
    end else if (running_o) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // [RL3] clock or tick source
  assign inc = running_o && (use_tick_i ? tick_i : pre_hit);
  assign hit = inc && (count_o == target_i);

  ////////////////////////////////////////////////////////////////////////
  // [RL4] one-shot or periodic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_o <= '0;
      running_o <= 1'b0;
    end else if (start_i) begin
      count_o <= '0;
      running_o <= 1'b1;
    end else if (stop_i) begin
      running_o <= 1'b0;
    end else if (hit) begin
      if (periodic_i) begin
        count_o <= '0;
      end else begin
        // [RL11] stop and hold count
        running_o <= 1'b0;
      end
    end else if (inc) begin
      count_o <= count_o + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_o <= 1'b0;
    end else begin
      done_o <= hit && !start_i && !stop_i;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/sdt_pkg.sv ====
`default_nettype none
package sdt_pkg;
  // register byte offsets
  localparam logic [7:0] T0_CTRL_OFF = 8'h00;
  localparam logic [7:0] T0_TARGET_OFF = 8'h04;
  localparam logic [7:0] T0_COUNT_OFF = 8'h08;
  localparam logic [7:0] T1_CTRL_OFF = 8'h10;
  localparam logic [7:0] T1_TARGET_OFF = 8'h14;
  localparam logic [7:0] T1_COUNT_OFF = 8'h18;
  localparam logic [7:0] T2_CTRL_OFF = 8'h20;
  localparam logic [7:0] T2_PERIOD_OFF = 8'h24;
  localparam logic [7:0] T2_COUNT_OFF = 8'h28;
  localparam logic [7:0] T2_EVSEL_OFF = 8'h2c;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h30;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h34;
  localparam logic [7:0] CH_CFG_OFF = 8'h40;
  localparam logic [7:0] CH_VAL_OFF = 8'h44;
  localparam logic [7:0] CH_STRIDE = 8'h08;
  // basic timer control fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_PERIODIC_BIT = 1;
  localparam int CTRL_USE_TICK_BIT = 2;
  localparam int CTRL_PRESC_LSB = 4;
  localparam int CTRL_TSEL_LSB = 8;
  // timer2 control fields
  localparam int T2_CLKSEL_LSB = 2;
  localparam logic [1:0] T2_CLK_24M = 2'h0;
  localparam logic [1:0] T2_CLK_2M = 2'h1;
  localparam logic [1:0] T2_CLK_32K = 2'h2;
  // event select fields
  localparam int EVSEL_SE_LSB = 0;
  localparam int EVSEL_ADC_LSB = 8;
  // channel config fields
  localparam int CH_EN_BIT = 0;
  localparam int CH_CAPTURE_BIT = 1;
  localparam int CH_PERIODIC_BIT = 2;
  // irq status layout
  localparam int IRQ_T0_BIT = 0;
  localparam int IRQ_T1_BIT = 1;
  localparam int IRQ_T2_BIT = 2;
  localparam int IRQ_CH_LSB = 3;
  localparam int IRQ_W = 7;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] TARGET_RST = 16'hffff;
  localparam logic [31:0] EVSEL_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 7'h00;
  // timer2 rate generation, in kHz
  localparam int SYS_CLK_KHZ = 100000;
  localparam int T2_F24_KHZ = 24000;
  localparam int T2_F2_KHZ = 2000;
  localparam int T2_F32_KHZ = 32;
  localparam int ACC_W = 18;
endpackage
`default_nettype wire

// ==== rtl/sdt_top.sv ====
// How it works
// [RL1] Three independent timers: two basic prescaled timers and one capture/compare timer.
// [RL2] Each basic timer has a 16-bit count fed through a power-of-two prescaler set by software.
// [RL3] Each basic timer counts its prescaled clock or every edge of a chosen tick input.
// [RL4] Each basic timer runs either one period only or restarts after every period.
// [RL5] The capture/compare timer has a 16-bit count at a chosen 24 MHz, 2 MHz or 32 kHz rate.
// [RL6] The capture/compare timer runs and raises events with no regard to the processor's state.
// [RL7] The capture/compare timer has four channels, each capturing or comparing the count.
// [RL8] Each channel acts either once only or again in every timer period.
// [RL9] Timer events are pulsed to the processor and to the converter trigger; only timer2 wrap and channel events are routed, not basic timer events.
// [RL10] Each channel output toggles on its compare match, giving pulse-width or waveform outputs.
// [RL11] A one-shot timer stops and holds its count once its target is reached, until restarted.
// [RL12] Software sets up a timer while it is stopped and starts it afterwards.
`default_nettype none
module sdt_top #(
  parameter int NUM_TICK = 8,
  parameter int NUM_CH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_TICK-1:0] tick_src,
  input wire logic [NUM_CH-1:0] cap_in,
  output logic [NUM_CH-1:0] cc_out,
  output logic proc_evt,
  output logic adc_trig,
  output logic irq
);
  localparam int EV_W = NUM_CH + 1;
  localparam int IRQ_W_L = sdt_pkg::IRQ_W;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers and edge detect
  logic [NUM_TICK-1:0] tick_s1_q;
  logic [NUM_TICK-1:0] tick_s2_q;
  logic [NUM_TICK-1:0] tick_s3_q;
  logic [NUM_TICK-1:0] tick_edge;
  logic [NUM_CH-1:0] cap_s1_q;
  logic [NUM_CH-1:0] cap_s2_q;
  logic [NUM_CH-1:0] cap_s3_q;
  logic [NUM_CH-1:0] cap_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_s1_q <= '0;
      tick_s2_q <= '0;
      tick_s3_q <= '0;
      cap_s1_q <= '0;
      cap_s2_q <= '0;
      cap_s3_q <= '0;
    end else begin
      tick_s1_q <= tick_src;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
      cap_s1_q <= cap_in;
      cap_s2_q <= cap_s1_q;
      cap_s3_q <= cap_s2_q;
    end
  end

  // both edges count as ticks
  assign tick_edge = tick_s2_q ^ tick_s3_q;
  assign cap_rise = cap_s2_q & ~cap_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  logic acc_ph;
  logic wr_en;
  logic [31:0] t_ctrl_q [2];
  logic [15:0] t_target_q [2];
  logic [31:0] t2_ctrl_q;
  logic [15:0] t2_period_q;
  logic [31:0] evsel_q;
  logic [IRQ_W_L-1:0] irq_status_q;
  logic [IRQ_W_L-1:0] irq_mask_q;
  logic [31:0] ch_cfg_q [NUM_CH];
  logic [15:0] ch_val_q [NUM_CH];

  assign acc_ph = psel && penable;
  assign wr_en = acc_ph && pwrite;
  assign pready = 1'b1;

  function automatic logic wr_at(input logic [7:0] off);
    wr_at = (paddr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // basic timer registers and start/stop pulses
  logic [1:0] t_start;
  logic [1:0] t_stop;
  logic [15:0] t_count [2];
  logic [1:0] t_run;
  logic [1:0] t_done;
  logic [7:0] t_base [2];

  assign t_base[0] = sdt_pkg::T0_CTRL_OFF;
  assign t_base[1] = sdt_pkg::T1_CTRL_OFF;

  // [RL1] two basic timers
  for (genvar k = 0; k < 2; k++) begin : g_basic
    logic ctrl_wr;
    logic [2:0] tsel;
    assign ctrl_wr = wr_en && wr_at(t_base[k]);
    // [RL12] run bit written last
    assign t_start[k] = ctrl_wr && pwdata[sdt_pkg::CTRL_RUN_BIT];
    assign t_stop[k] = ctrl_wr && !pwdata[sdt_pkg::CTRL_RUN_BIT];
    assign tsel = t_ctrl_q[k][sdt_pkg::CTRL_TSEL_LSB +: 3];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        t_ctrl_q[k] <= sdt_pkg::CTRL_RST;
        t_target_q[k] <= sdt_pkg::TARGET_RST;
      end else begin
        if (ctrl_wr) begin
          t_ctrl_q[k] <= pwdata;
        end
        if (wr_en && wr_at(t_base[k] + 8'h04)) begin
          t_target_q[k] <= pwdata[15:0];
        end
      end
    end

    // [RL3] tick select and mode
    sdt_basic_timer #(
      .CNT_W(16),
      .PRESC_W(4)
    ) u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .start_i(t_start[k]),
      .stop_i(t_stop[k]),
      .periodic_i(t_ctrl_q[k][sdt_pkg::CTRL_PERIODIC_BIT]),
      .use_tick_i(t_ctrl_q[k][sdt_pkg::CTRL_USE_TICK_BIT]),
      .prescale_i(t_ctrl_q[k][sdt_pkg::CTRL_PRESC_LSB +: 4]),
      .tick_i(tick_edge[tsel]),
      .target_i(t_target_q[k]),
      .count_o(t_count[k]),
      .running_o(t_run[k]),
      .done_o(t_done[k])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // timer2 rate generator
  logic [sdt_pkg::ACC_W-1:0] rate_acc_q;
  logic [sdt_pkg::ACC_W-1:0] rate_inc;
  logic [sdt_pkg::ACC_W-1:0] rate_sum;
  logic t2_tick;
  logic t2_start;
  logic t2_stop;
  logic [15:0] t2_count;
  logic t2_run;
  logic t2_wrap;

  // [RL5] 24 MHz, 2 MHz or 32 kHz
  always_comb begin
    case (t2_ctrl_q[sdt_pkg::T2_CLKSEL_LSB +: 2])
      sdt_pkg::T2_CLK_24M: rate_inc = sdt_pkg::ACC_W'(sdt_pkg::T2_F24_KHZ);
      sdt_pkg::T2_CLK_2M: rate_inc = sdt_pkg::ACC_W'(sdt_pkg::T2_F2_KHZ);
      sdt_pkg::T2_CLK_32K: rate_inc = sdt_pkg::ACC_W'(sdt_pkg::T2_F32_KHZ);
      default: rate_inc = sdt_pkg::ACC_W'(sdt_pkg::T2_F24_KHZ);
    endcase
  end

  assign rate_sum = rate_acc_q + rate_inc;
  assign t2_tick = t2_run && (rate_sum >= sdt_pkg::ACC_W'(sdt_pkg::SYS_CLK_KHZ));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_acc_q <= '0;
    end else if (!t2_run) begin
      rate_acc_q <= '0;
    end else if (t2_tick) begin
      rate_acc_q <= rate_sum - sdt_pkg::ACC_W'(sdt_pkg::SYS_CLK_KHZ);
    end else begin
      rate_acc_q <= rate_sum;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timer2 registers and counter
  assign t2_start = wr_en && wr_at(sdt_pkg::T2_CTRL_OFF) && pwdata[sdt_pkg::CTRL_RUN_BIT];
  assign t2_stop = wr_en && wr_at(sdt_pkg::T2_CTRL_OFF) && !pwdata[sdt_pkg::CTRL_RUN_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t2_ctrl_q <= sdt_pkg::CTRL_RST;
      t2_period_q <= sdt_pkg::TARGET_RST;
      evsel_q <= sdt_pkg::EVSEL_RST;
    end else begin
      if (wr_en && wr_at(sdt_pkg::T2_CTRL_OFF)) begin
        t2_ctrl_q <= pwdata;
      end
      if (wr_en && wr_at(sdt_pkg::T2_PERIOD_OFF)) begin
        t2_period_q <= pwdata[15:0];
      end
      if (wr_en && wr_at(sdt_pkg::T2_EVSEL_OFF)) begin
        evsel_q <= pwdata;
      end
    end
  end

  // [RL6] no processor state input
  sdt_basic_timer #(
    .CNT_W(16),
    .PRESC_W(4)
  ) u_t2 (
    .pclk(pclk),
    .presetn(presetn),
    .start_i(t2_start),
    .stop_i(t2_stop),
    .periodic_i(t2_ctrl_q[sdt_pkg::CTRL_PERIODIC_BIT]),
    .use_tick_i(1'b1),
    .prescale_i(4'h0),
    .tick_i(t2_tick),
    .target_i(t2_period_q),
    .count_o(t2_count),
    .running_o(t2_run),
    .done_o(t2_wrap)
  );

  ////////////////////////////////////////////////////////////////////////
  // capture/compare channels
  logic [NUM_CH-1:0] ch_evt_q;

  // [RL7] four capture or compare channels
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [7:0] cfg_off;
    logic [7:0] val_off;
    logic en;
    logic is_cap;
    logic match;
    logic fire;
    assign cfg_off = sdt_pkg::CH_CFG_OFF + 8'(c) * sdt_pkg::CH_STRIDE;
    assign val_off = sdt_pkg::CH_VAL_OFF + 8'(c) * sdt_pkg::CH_STRIDE;
    assign en = ch_cfg_q[c][sdt_pkg::CH_EN_BIT];
    assign is_cap = ch_cfg_q[c][sdt_pkg::CH_CAPTURE_BIT];
    assign match = t2_tick && (t2_count == ch_val_q[c]);
    assign fire = en && (is_cap ? (cap_rise[c] && t2_run) : match);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ch_cfg_q[c] <= sdt_pkg::CTRL_RST;
      end else if (wr_en && wr_at(cfg_off)) begin
        ch_cfg_q[c] <= pwdata;
      end else if (fire && !ch_cfg_q[c][sdt_pkg::CH_PERIODIC_BIT]) begin
        // [RL8] one-shot disarms after acting
        ch_cfg_q[c][sdt_pkg::CH_EN_BIT] <= 1'b0;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ch_val_q[c] <= '0;
      end else if (wr_en && wr_at(val_off)) begin
        ch_val_q[c] <= pwdata[15:0];
      end else if (fire && is_cap) begin
        ch_val_q[c] <= t2_count;
      end
    end

    // [RL10] output toggles on match
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cc_out[c] <= 1'b0;
      end else if (fire && !is_cap) begin
        cc_out[c] <= ~cc_out[c];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ch_evt_q[c] <= 1'b0;
      end else begin
        ch_evt_q[c] <= fire;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event routing
  logic [EV_W-1:0] t2_events;
  logic t2_wrap_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t2_wrap_q <= 1'b0;
    end else begin
      t2_wrap_q <= t2_wrap;
    end
  end

  assign t2_events = {ch_evt_q, t2_wrap_q};

  // [RL9] processor and converter events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proc_evt <= 1'b0;
      adc_trig <= 1'b0;
    end else begin
      proc_evt <= |(t2_events & evsel_q[sdt_pkg::EVSEL_SE_LSB +: EV_W]);
      adc_trig <= |(t2_events & evsel_q[sdt_pkg::EVSEL_ADC_LSB +: EV_W]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and output
  logic [IRQ_W_L-1:0] irq_set;

  assign irq_set = {ch_evt_q, t2_wrap_q, t_done};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
      irq_mask_q <= sdt_pkg::IRQ_MASK_RST;
    end else begin
      if (wr_en && wr_at(sdt_pkg::IRQ_STATUS_OFF)) begin
        irq_status_q <= (irq_status_q & ~pwdata[IRQ_W_L-1:0]) | irq_set;
      end else begin
        irq_status_q <= irq_status_q | irq_set;
      end
      if (wr_en && wr_at(sdt_pkg::IRQ_MASK_OFF)) begin
        irq_mask_q <= pwdata[IRQ_W_L-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, sampled in the setup cycle
  logic [31:0] rd_d;
  logic rd_err_d;

  always_comb begin
    rd_d = 32'h0000_0000;
    rd_err_d = 1'b0;
    case (paddr)
      sdt_pkg::T0_CTRL_OFF: rd_d = {t_ctrl_q[0][31:1], t_run[0]};
      sdt_pkg::T0_TARGET_OFF: rd_d = {16'h0000, t_target_q[0]};
      sdt_pkg::T0_COUNT_OFF: rd_d = {16'h0000, t_count[0]};
      sdt_pkg::T1_CTRL_OFF: rd_d = {t_ctrl_q[1][31:1], t_run[1]};
      sdt_pkg::T1_TARGET_OFF: rd_d = {16'h0000, t_target_q[1]};
      sdt_pkg::T1_COUNT_OFF: rd_d = {16'h0000, t_count[1]};
      sdt_pkg::T2_CTRL_OFF: rd_d = {t2_ctrl_q[31:1], t2_run};
      sdt_pkg::T2_PERIOD_OFF: rd_d = {16'h0000, t2_period_q};
      sdt_pkg::T2_COUNT_OFF: rd_d = {16'h0000, t2_count};
      sdt_pkg::T2_EVSEL_OFF: rd_d = evsel_q;
      sdt_pkg::IRQ_STATUS_OFF: rd_d = {{(32 - IRQ_W_L){1'b0}}, irq_status_q};
      sdt_pkg::IRQ_MASK_OFF: rd_d = {{(32 - IRQ_W_L){1'b0}}, irq_mask_q};
      default: rd_err_d = 1'b1;
    endcase
    for (int c = 0; c < NUM_CH; c++) begin
      if (paddr == sdt_pkg::CH_CFG_OFF + 8'(c) * sdt_pkg::CH_STRIDE) begin
        rd_d = ch_cfg_q[c];
        rd_err_d = 1'b0;
      end
      if (paddr == sdt_pkg::CH_VAL_OFF + 8'(c) * sdt_pkg::CH_STRIDE) begin
        rd_d = {16'h0000, ch_val_q[c]};
        rd_err_d = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr <= rd_err_d;
    end
  end
endmodule
`default_nettype wire
